// ### design/dmba_params.svh
/*
 Timing and encoding constants for the dual-master bus arbiter.
 Assumes inclusion by the arbiter package and top module only.
*/
`ifndef DMBA_PARAMS_SVH
`define DMBA_PARAMS_SVH

`define DMBA_CLOCK_PERIOD_NS   25
`define DMBA_SYNC_STAGES       2
`define DMBA_GAP_EDGES         1
`define DMBA_SCHEME_WIDTH      3
`define DMBA_SCHEME_FAIR       3'h0
`define DMBA_SCHEME_PRIO       3'h1
`define DMBA_SCHEME_SDMA_CPU   3'h2
`define DMBA_SCHEME_SDMA_DMA   3'h3
`define DMBA_SCHEME_ADMA_DMA   3'h4
`define DMBA_SCHEME_ADMA_CPU   3'h5

`endif

// ### design/dmba_pkg.sv
/*
 Types for the dual-master bus arbiter.
 Assumes dmba_params.svh is on the include path.
*/
`include "dmba_params.svh"

package dmba_pkg;

   typedef enum logic [2:0] {
      DMBA_FAIR          = `DMBA_SCHEME_FAIR,
      DMBA_PRIO          = `DMBA_SCHEME_PRIO,
      DMBA_SDMA_CPU_HIGH = `DMBA_SCHEME_SDMA_CPU,
      DMBA_SDMA_DMA_HIGH = `DMBA_SCHEME_SDMA_DMA,
      DMBA_ADMA_DMA_HIGH = `DMBA_SCHEME_ADMA_DMA,
      DMBA_ADMA_CPU_HIGH = `DMBA_SCHEME_ADMA_CPU
   } dmba_scheme_t;

   // A: master 1 owns, B: grant moving to 2, C: master 2 owns, D: grant moving to 1
   typedef enum logic [2:0] {
      DMBA_ST_A   = 3'h0,
      DMBA_ST_B   = 3'h1,
      DMBA_ST_C   = 3'h2,
      DMBA_ST_D   = 3'h3,
      DMBA_ST_GAP1 = 3'h4,
      DMBA_ST_GAP2 = 3'h5
   } dmba_state_t;

endpackage : dmba_pkg

// ### design/dmba_arbiter.sv
/*
 External arbiter for a shared bus with two masters: two processors,
 or a processor (master 1) and a DMA master (master 2).
 Assumes all pins except an asynchronous DMA's are synchronous to clock;
 the scheme input is static while out of reset. Bus pins are active low; retry_locked_allowed is active high.
*/
// Summary of operation
// - Fairness: current owner gets lowest priority
// - Nonlocked access: move grant to master 2
// - Leave B for C only when bus-busy negated
// - Locked access: hold until sequence-last asserted
// - Boundary: watch new lock, return grant
// - Regrant after one clock, no waiting
// - Retry-capable system: ignore sequence-last
// - Prioritized: master 2 only without master 1
// - Prioritized: locked master 2 keeps bus
// - Request input stands in for lock
// - Processor is default owner when idle
// - CPU-high DMA: grant DMA when CPU idle
// - DMA-high: preempt CPU except when locked
// - Async DMA inputs need two edges
// - Async DMA-high: yield after indeterminate resolved
// - Async DMA-low: DMA only when CPU idle
// - Async DMA-low waits busy/transfer negated
// - All grants negated one edge between tenures
`timescale 1ns/1ps
`include "dmba_params.svh"

module dmba_arbiter (
   input  wire logic                  clock,
   input  wire logic                  rst_b,
   input  wire dmba_pkg::dmba_scheme_t scheme,
   input  wire logic                  retry_locked_allowed,
   input  wire logic                  master1_request_n,
   input  wire logic                  master2_request_n,
   input  wire logic                  bus_busy_n,
   input  wire logic                  transfer_in_progress_n,
   input  wire logic                  atomic_sequence_n,
   input  wire logic                  atomic_sequence_last_n,
   output logic                       master1_grant_n,
   output logic                       master2_grant_n,
   output dmba_pkg::dmba_state_t      arbiter_state
);
   import dmba_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Asynchronous DMA input conditioning

   logic [1:0] dma_meta_reg;
   logic [1:0] dma_sync_reg;
   logic [1:0] dma_prev_reg;
   logic [1:0] dma_raw;
   logic       dma_req;
   logic       dma_stable;
   logic       async_mode;

   assign async_mode = (scheme == DMBA_ADMA_DMA_HIGH) || (scheme == DMBA_ADMA_CPU_HIGH);
   // The DMA's own busy shares the busy wire; only its request is async
   assign dma_raw = {~master2_request_n, 1'b0};

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_sync
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               dma_meta_reg[g] <= 1'b0;
               dma_sync_reg[g] <= 1'b0;
               dma_prev_reg[g] <= 1'b0;
            end else begin
               dma_meta_reg[g] <= dma_raw[g];
               dma_sync_reg[g] <= dma_meta_reg[g];
               dma_prev_reg[g] <= dma_sync_reg[g];
            end
         end
      end
   endgenerate

   assign dma_stable = (dma_sync_reg[1] == dma_prev_reg[1]);
   assign dma_req    = async_mode ? dma_sync_reg[1] : ~master2_request_n;

   ////////////////////////////////////////////////////////////////////////////
   // Sampled request and status terms

   logic req1;
   logic req2;
   logic busy;
   logic locked1;
   logic lock_last;
   logic cpu_idle;
   logic hold_inputs;

   // pins decoded unregistered except the async DMA request, which is synchronized; read at clock edges
   assign req1 = ~master1_request_n;
   assign req2 = dma_req;
   assign busy = ~bus_busy_n;
   assign locked1 = ~atomic_sequence_n;
   assign lock_last = ~atomic_sequence_last_n & ~retry_locked_allowed;
   // bus idle means busy and transfer negated
   assign cpu_idle = bus_busy_n & transfer_in_progress_n;
   assign hold_inputs = async_mode & ~dma_stable;

   ////////////////////////////////////////////////////////////////////////////
   // Decisions per scheme

   logic want_to_2;
   logic want_to_1;
   logic reclaim_1;

   always_comb begin
      want_to_2 = 1'b0;
      want_to_1 = 1'b0;
      case (scheme)
         DMBA_FAIR: begin
            // owner yields when the other requests, master 1 not while locked
            want_to_2 = req2 & (~locked1 | lock_last);
            // regrant at once, no wait for a cycle
            want_to_1 = req1;
         end
         DMBA_PRIO: begin
            // master 2 only without master 1 request
            want_to_2 = req2 & ~req1;
            // locked master 2 keeps the bus
            want_to_1 = req1 & atomic_sequence_n;
         end
         DMBA_SDMA_CPU_HIGH: begin
            // DMA only when processor not requesting
            want_to_2 = req2 & ~req1 & ~locked1;
            want_to_1 = req1 | ~req2;
         end
         DMBA_SDMA_DMA_HIGH: begin
            want_to_2 = req2 & ~locked1;
            want_to_1 = ~req2;
         end
         DMBA_ADMA_DMA_HIGH: begin
            want_to_2 = req2 & ~locked1;
            want_to_1 = ~req2;
         end
         DMBA_ADMA_CPU_HIGH: begin
            want_to_2 = req2 & ~req1 & cpu_idle & ~locked1;
            want_to_1 = req1 | ~req2;
         end
         default: begin
            want_to_2 = 1'b0;
            want_to_1 = 1'b1;
         end
      endcase
   end

   // new locked access in B returns the bus
   // busy with lock means master 1 kept it
   assign reclaim_1 = locked1 & busy;

   ////////////////////////////////////////////////////////////////////////////
   // State machine

   dmba_state_t state_reg;
   dmba_state_t state_next;
   logic        grant1_next;
   logic        grant2_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         DMBA_ST_A: begin
            // nonlocked access gives grant to master 2
            if (!hold_inputs && want_to_2)
               state_next = DMBA_ST_GAP1;
         end
         DMBA_ST_GAP1: begin
            state_next = DMBA_ST_B;
         end
         DMBA_ST_B: begin
            // Grant goes back to master 1 through a gap edge so both grants are never swapped in one edge
            if (reclaim_1 && !lock_last)
               state_next = DMBA_ST_GAP2;
            // master 2 then finds grant and idle bus
            else if (!busy)
               state_next = DMBA_ST_C;
         end
         DMBA_ST_C: begin
            // no wait for master 2 to run a cycle
            // in the DMA schemes the bus goes back to the processor once the DMA stops requesting
            if (!hold_inputs && want_to_1)
               state_next = DMBA_ST_GAP2;
         end
         DMBA_ST_GAP2: begin
            state_next = DMBA_ST_D;
         end
         DMBA_ST_D: begin
            if (!busy)
               state_next = DMBA_ST_A;
         end
         default: begin
            state_next = DMBA_ST_A;
         end
      endcase
   end

   assign grant1_next = (state_next == DMBA_ST_A) || (state_next == DMBA_ST_D);
   assign grant2_next = (state_next == DMBA_ST_B) || (state_next == DMBA_ST_C);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg       <= DMBA_ST_A;
         master1_grant_n <= 1'b0;
         master2_grant_n <= 1'b1;
         arbiter_state   <= DMBA_ST_A;
      end else begin
         state_reg       <= state_next;
         master1_grant_n <= ~grant1_next;
         master2_grant_n <= ~grant2_next;
         arbiter_state   <= state_next;
      end
   end

endmodule // dmba_arbiter

// ### dv/dmba_properties.sv
/* Port checker for dmba_arbiter.
   Assumes it is bound into every dmba_arbiter instance. */
`timescale 1ns/1ps
module dmba_properties (
   input wire logic                   clock,
   input wire logic                   rst_b,
   input wire dmba_pkg::dmba_scheme_t scheme,
   input wire logic                   master1_request_n,
   input wire logic                   bus_busy_n,
   input wire logic                   atomic_sequence_n,
   input wire logic                   atomic_sequence_last_n,
   input wire logic                   master1_grant_n,
   input wire logic                   master2_grant_n,
   input wire dmba_pkg::dmba_state_t  arbiter_state
);
   import dmba_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_gap_before_m2: assert property ($fell(master2_grant_n) |-> $past(master1_grant_n))
      else $error("grant 2 without gap");
   a_gap_before_m1: assert property ($fell(master1_grant_n) |-> $past(master2_grant_n))
      else $error("grant 1 without gap");
   a_gap_one_cycle: assert property ($rose(master1_grant_n) |=> !master2_grant_n)
      else $error("gap not one cycle");
   a_b_waits_busy: assert property (arbiter_state == DMBA_ST_B && !bus_busy_n |=> arbiter_state != DMBA_ST_C)
      else $error("left B while busy");
   a_b_to_c: assert property (scheme == DMBA_FAIR && arbiter_state == DMBA_ST_B && bus_busy_n && atomic_sequence_n
      |=> arbiter_state == DMBA_ST_C) else $error("B did not advance");
   a_locked_hold: assert property (scheme == DMBA_FAIR && arbiter_state == DMBA_ST_A && !atomic_sequence_n
      && atomic_sequence_last_n |=> arbiter_state == DMBA_ST_A) else $error("locked owner lost bus");
   a_b_reclaim: assert property (scheme == DMBA_FAIR && arbiter_state == DMBA_ST_B && !bus_busy_n
      && !atomic_sequence_n && atomic_sequence_last_n |=> arbiter_state == DMBA_ST_GAP2)
      else $error("lock in B not reclaimed");
   a_prio_master1: assert property (scheme == DMBA_PRIO && arbiter_state == DMBA_ST_A && !master1_request_n
      |=> arbiter_state == DMBA_ST_A) else $error("low priority granted");
   a_reset_state: assert property ($rose(rst_b) |-> arbiter_state == DMBA_ST_A && !master1_grant_n
      && master2_grant_n) else $error("bad reset state");
endmodule // dmba_properties
bind dmba_arbiter dmba_properties chk_u (.clock, .rst_b, .scheme, .master1_request_n, .bus_busy_n,
   .atomic_sequence_n, .atomic_sequence_last_n, .master1_grant_n, .master2_grant_n, .arbiter_state);

// ### dv/dmba_master_model.sv
/* Behavioural pair of bus masters sharing one busy line.
   Assumes the bench drives the requests and the tenure length. */
`timescale 1ns/1ps
module dmba_master_model (
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       master1_grant_n,
   input  wire logic       master2_grant_n,
   input  wire logic       master1_request_n,
   input  wire logic       master2_request_n,
   input  wire logic [3:0] hold,
   output logic            bus_busy_n,
   output logic            transfer_in_progress_n
);
   logic [3:0] count_reg;
   wire take = count_reg == 4'h0 && (!master1_grant_n && !master1_request_n || !master2_grant_n && !master2_request_n);
   // requests come from the bench freely
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) count_reg <= 4'h0;
      else if (take) count_reg <= hold;
      else if (count_reg != 4'h0) count_reg <= count_reg - 4'h1;
   end
   assign bus_busy_n = count_reg == 4'h0;
   assign transfer_in_progress_n = bus_busy_n;
endmodule // dmba_master_model

// ### dv/dmba_arbiter_tb.sv
/* Self-checking bench for dmba_arbiter with a behavioural master pair.
   Assumes the design package and header are compiled first. */
`timescale 1ns/1ps
module dmba_arbiter_tb;
   import dmba_pkg::*;
   logic         clock = 1'b0;
   logic         rst_b = 1'b0;
   dmba_scheme_t scheme = DMBA_FAIR;
   logic         retry_locked_allowed = 1'b0;
   logic         master1_request_n = 1'b1;
   logic         master2_request_n = 1'b1;
   logic         atomic_sequence_n = 1'b1;
   logic         atomic_sequence_last_n = 1'b1;
   logic [3:0]   hold = 4'h3;
   logic         bus_busy_n, transfer_in_progress_n, master1_grant_n, master2_grant_n;
   dmba_state_t  arbiter_state;
   int           fail_count = 0;
   int           checks_done = 0;
   always #12.5 clock = ~clock;
   dmba_arbiter dut_u (.clock, .rst_b, .scheme, .retry_locked_allowed, .master1_request_n, .master2_request_n,
      .bus_busy_n, .transfer_in_progress_n, .atomic_sequence_n, .atomic_sequence_last_n, .master1_grant_n,
      .master2_grant_n, .arbiter_state);
   dmba_master_model model_u (.clock, .rst_b, .master1_grant_n, .master2_grant_n, .master1_request_n,
      .master2_request_n, .hold, .bus_busy_n, .transfer_in_progress_n);
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [4:0] got, input logic [4:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic expect_now(input logic [4:0] exp);
      check({master1_grant_n, master2_grant_n, arbiter_state}, exp);
   endtask
   task automatic wait_state(input dmba_state_t st);
      for (int i = 0; i < 40; i++) begin
         @(posedge clock);
         #1;
         if (arbiter_state === st) return;
      end
      check({2'b00, arbiter_state}, {2'b00, st});
      end_of_test();
   endtask
   task automatic start(input dmba_scheme_t s);
      @(posedge clock);
      rst_b <= 1'b0;
      scheme <= s;
      {retry_locked_allowed, master1_request_n, master2_request_n} <= 3'h3;
      {atomic_sequence_n, atomic_sequence_last_n} <= 2'h3;
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      #1;
      expect_now({2'b01, DMBA_ST_A});
      @(posedge clock);
   endtask
   task automatic fair_handoff();
      start(DMBA_FAIR);
      master1_request_n <= 1'b0;
      master2_request_n <= 1'b0;
      wait_state(DMBA_ST_GAP1);
      expect_now({2'b11, DMBA_ST_GAP1});
      wait_state(DMBA_ST_C);
      @(posedge clock);
      #1;
      expect_now({2'b11, DMBA_ST_GAP2});
      wait_state(DMBA_ST_A);
      expect_now({2'b01, DMBA_ST_A});
      wait_state(DMBA_ST_GAP1);
      expect_now({2'b11, DMBA_ST_GAP1});
   endtask
   task automatic lock_hold();
      start(DMBA_FAIR);
      {retry_locked_allowed, atomic_sequence_n, atomic_sequence_last_n, master2_request_n} <= 4'h8;
      repeat (6) @(posedge clock);
      #1;
      expect_now({2'b01, DMBA_ST_A});
      @(posedge clock);
      {retry_locked_allowed, atomic_sequence_last_n} <= 2'h1;
      repeat (6) @(posedge clock);
      #1;
      expect_now({2'b01, DMBA_ST_A});
      @(posedge clock);
      atomic_sequence_last_n <= 1'b0;
      wait_state(DMBA_ST_GAP1);
   endtask
   task automatic lock_reclaim();
      start(DMBA_FAIR);
      hold <= 4'h6;
      {master1_request_n, master2_request_n} <= 2'h0;
      wait_state(DMBA_ST_GAP1);
      @(posedge clock);
      atomic_sequence_n <= 1'b0;
      wait_state(DMBA_ST_GAP2);
      expect_now({2'b11, DMBA_ST_GAP2});
      wait_state(DMBA_ST_A);
      expect_now({2'b01, DMBA_ST_A});
      @(posedge clock);
      hold <= 4'h3;
      atomic_sequence_n <= 1'b1;
   endtask
   task automatic prio_order();
      start(DMBA_PRIO);
      {master1_request_n, master2_request_n} <= 2'h0;
      repeat (6) @(posedge clock);
      #1;
      expect_now({2'b01, DMBA_ST_A});
      @(posedge clock);
      master1_request_n <= 1'b1;
      wait_state(DMBA_ST_GAP1);
   endtask
   task automatic dma_schemes();
      for (int s = 2; s < 6; s++) begin
         start(dmba_scheme_t'(s));
         master2_request_n <= s < 4;
         @(posedge clock);
         master2_request_n <= 1'b1;
         repeat (6) @(posedge clock);
         #1;
         expect_now({2'b01, DMBA_ST_A});
         @(posedge clock);
         {master1_request_n, master2_request_n} <= 2'h0;
         repeat (10) @(posedge clock);
         #1;
         check({4'h0, master1_grant_n}, {4'h0, s == 3 || s == 4});
      end
   endtask
   initial begin
      fair_handoff();
      lock_hold();
      lock_reclaim();
      prio_order();
      dma_schemes();
      end_of_test();
   end
endmodule // dmba_arbiter_tb
